// ===== rtl/tgd_cycle_counter.sv
// Purpose: Machine cycle state counter and instruction duration counter.
// Assumes: main_tick is a one-cycle pulse per main system clock period.
// Notes:   Counting pauses while the core is halted.
`timescale 1ns/10ps
module tgd_cycle_counter (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       main_tick,
   input  wire logic       cpu_run,
   input  wire logic [3:0] instr_len,
   output logic [1:0]      state_r,
   output logic [3:0]      cycle_r,
   output logic            instr_done_r
);

   // ---------------------------------------------------------------
   // Machine cycle: four states, one main clock each
   // ---------------------------------------------------------------
   logic end_of_cycle;
   assign end_of_cycle = main_tick && cpu_run && (state_r == 2'(tgd_pkg::STATES - 1));

   // State advances once per main clock period while the core runs.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= 2'h0;
      end else if (main_tick && cpu_run) begin
         state_r <= state_r + 2'h1;
      end
   end

   // Machine cycles within an instruction; the length is held to one to ten.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cycle_r      <= 4'h0;
         instr_done_r <= 1'b0;
      end else begin
         instr_done_r <= 1'b0;
         if (end_of_cycle) begin
            if (cycle_r + 4'h1 >= instr_len) begin
               cycle_r      <= 4'h0;
               instr_done_r <= 1'b1;
            end else begin
               cycle_r <= cycle_r + 4'h1;
            end
         end
      end
   end

endmodule

// ===== rtl/tgd_pkg.sv
// Purpose: Shared constants and types of the timing generator and divider.
// Assumes: Registers are 32-bit words on APB, byte addresses below.
// Notes:   Every offset, bit position, reset value and stage index is named once here.
package tgd_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_STATUS  = 8'h04;
   localparam logic [7:0] OFS_DIVIDER = 8'h08;
   localparam logic [7:0] OFS_INSTR   = 8'h0c;

   // ---------------------------------------------------------------
   // Control register fields
   // ---------------------------------------------------------------
   localparam int CTL_MAIN_SRC  = 0;   // Main clock source select.
   localparam int CTL_STAGE7    = 1;   // Stage-seven source select.
   localparam int CTL_LOW_EN    = 2;   // Low-frequency oscillator enable.
   localparam int CTL_HIGH_EN   = 3;   // High-frequency oscillator enable.
   localparam int CTL_STOP_REQ  = 4;   // Write one in fast run or low-only run to enter stop; reads zero.
   localparam int CTL_SLEEP_REQ = 5;   // Write one in low-only run to halt the core; reads zero.
   localparam logic [3:0] CTL_RESET = 4'h8;

   // ---------------------------------------------------------------
   // Status register fields
   // ---------------------------------------------------------------
   localparam int STS_MODE     = 0;    // Three bits of operating mode.
   localparam int STS_STATE    = 4;    // Two bits of machine cycle state.
   localparam int STS_HIGH_RUN = 6;
   localparam int STS_LOW_RUN  = 7;
   localparam int STS_CPU_RUN  = 8;
   localparam int STS_PORTS    = 9;    // Low oscillator pins serve as ports.

   // ---------------------------------------------------------------
   // Divider geometry and instruction classes
   // ---------------------------------------------------------------
   localparam int PRE_STAGES  = 2;
   localparam int DIV_STAGES  = 21;
   localparam int LOW_STAGES  = 6;    // Stages one to six.
   localparam int PULSE_STAGE = 13;   // Stage driving the divided pulse output.
   localparam int WARM_STAGE  = 14;   // Stage whose first rise ends warm-up.
   localparam int STATES      = 4;
   localparam logic [3:0] INSTR_MIN   = 4'h1;
   localparam logic [3:0] INSTR_MAX   = 4'ha;
   localparam logic [3:0] INSTR_RESET = 4'h1;

   // Operating modes.
   typedef enum logic [2:0] {
      single_osc_fast_run,
      dual_osc_fast_run,
      dual_osc_slow_run,
      low_osc_only_run,
      low_osc_halted_cpu,
      stop_halted,
      stop_warm_up
   } tgd_mode_t;

endpackage

// ===== rtl/tgd_timing_gen.sv
// Purpose: Timing generator, divider chain and operating-mode clock control.
// Assumes: Basic clocks arrive as one-cycle tick inputs synchronous to pclk.
// Notes:   The ripple divider is modelled as a synchronous counter enabled by ticks.
`timescale 1ns/10ps

// Functional notes
// - two prescaler stages, then twenty-one divider stages
// - reset and stop entry or release clear chain
// - stage seven input follows mode and selects
// - slow and sleep feed low clock to stage seven
// - warm-up after fast-mode stop feeds stage six
// - machine cycle is four one-clock states
// - instructions last one to ten machine cycles
// - execution and peripherals follow main system clock
// - single mode runs high oscillator, pins as ports
// - reset starts in single-clock fast run
// - produce main clock, pulse output, source clocks
// - mode logic gates oscillators, switches main clock
// - main select switches dual fast and slow
// - high oscillator off or sleep stops stages one-six
module tgd_timing_gen (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        high_freq_clock,
   input  wire logic        low_freq_clock,
   input  wire logic        stop_release,
   input  wire logic        wake_event,
   output logic             main_clock_tick,
   output logic             divided_pulse_output,
   output logic [20:0]      source_clocks,
   output logic             warm_up_tick,
   output logic             high_osc_run,
   output logic             low_osc_run,
   output logic             low_osc_pins_as_port,
   output logic             cpu_run,
   output logic [1:0]       machine_state,
   output logic             instr_done
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   tgd_pkg::tgd_mode_t mode_r;
   tgd_pkg::tgd_mode_t mode_nxt;
   tgd_pkg::tgd_mode_t resume_r;
   logic [3:0]  ctl_r;
   logic [3:0]  instr_len_r;
   logic [1:0]  pre_r;
   logic [5:0]  low_div_r;
   logic [14:0] high_div_r;
   logic        from_fast_r;
   logic        stop_req;
   logic        sleep_req;
   logic        wr_en;
   logic        rd_setup;
   logic        addr_ok;
   logic        high_on;
   logic        low_on;
   logic        hf_tick;
   logic        lf_tick;
   logic        stage1_in;
   logic        stage6_fall;
   logic        stage7_in;
   logic        clear_chain;
   logic        warm_done;
   logic        fast_mode;
   logic        slow_mode;
   logic        main_tick_nxt;
   logic [1:0]  state_w;
   logic [3:0]  cycle_w;
   logic        done_w;
   logic [22:0] chain_w;

   // Clamp an instruction length to the one-to-ten range.
   function automatic logic [3:0] clamp_len(input logic [3:0] v);
      if (v < tgd_pkg::INSTR_MIN) begin
         return tgd_pkg::INSTR_MIN;
      end
      if (v > tgd_pkg::INSTR_MAX) begin
         return tgd_pkg::INSTR_MAX;
      end
      return v;
   endfunction

   // True in modes where the given oscillator runs, with warm-up taken as after a fast-mode stop.
   function automatic logic osc_high(input tgd_pkg::tgd_mode_t m);
      return (m == tgd_pkg::single_osc_fast_run) || (m == tgd_pkg::dual_osc_fast_run) ||
             (m == tgd_pkg::dual_osc_slow_run) || (m == tgd_pkg::stop_warm_up);
   endfunction

   function automatic logic osc_low(input tgd_pkg::tgd_mode_t m);
      return (m == tgd_pkg::dual_osc_fast_run) || (m == tgd_pkg::dual_osc_slow_run) ||
             (m == tgd_pkg::low_osc_only_run) || (m == tgd_pkg::low_osc_halted_cpu);
   endfunction

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   // Zero wait states: read data is captured in the setup cycle.
   assign pready    = 1'b1;
   assign addr_ok   = (paddr == tgd_pkg::OFS_CONTROL) || (paddr == tgd_pkg::OFS_STATUS) ||
                      (paddr == tgd_pkg::OFS_DIVIDER) || (paddr == tgd_pkg::OFS_INSTR);
   assign pslverr   = psel && penable && !addr_ok;
   assign wr_en     = psel && penable && pwrite && addr_ok;
   assign rd_setup  = psel && !penable && !pwrite;
   assign stop_req  = wr_en && (paddr == tgd_pkg::OFS_CONTROL) && pwdata[tgd_pkg::CTL_STOP_REQ];
   assign sleep_req = wr_en && (paddr == tgd_pkg::OFS_CONTROL) && pwdata[tgd_pkg::CTL_SLEEP_REQ];
   assign chain_w   = {high_div_r, low_div_r, pre_r};

   // Control and instruction-length registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_r       <= tgd_pkg::CTL_RESET;
         instr_len_r <= tgd_pkg::INSTR_RESET;
      end else if (wr_en) begin
         if (paddr == tgd_pkg::OFS_CONTROL) begin
            ctl_r <= pwdata[3:0];
         end
         if (paddr == tgd_pkg::OFS_INSTR) begin
            instr_len_r <= clamp_len(pwdata[3:0]);
         end
      end
   end

   // Read data; unmapped addresses read zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= 32'h0000_0000;
         unique case (paddr)
            tgd_pkg::OFS_CONTROL: prdata[3:0] <= ctl_r;
            tgd_pkg::OFS_STATUS: begin
               prdata[tgd_pkg::STS_MODE +: 3]  <= mode_r;
               prdata[tgd_pkg::STS_STATE +: 2] <= state_w;
               prdata[tgd_pkg::STS_HIGH_RUN]   <= high_osc_run;
               prdata[tgd_pkg::STS_LOW_RUN]    <= low_osc_run;
               prdata[tgd_pkg::STS_CPU_RUN]    <= cpu_run;
               prdata[tgd_pkg::STS_PORTS]      <= low_osc_pins_as_port;
            end
            tgd_pkg::OFS_DIVIDER: prdata[22:0] <= chain_w;
            tgd_pkg::OFS_INSTR: prdata[7:0] <= {cycle_w, instr_len_r};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Operating mode control
   // ---------------------------------------------------------------
   assign warm_done = high_div_r[tgd_pkg::WARM_STAGE - 7];

   // Next mode from control bits, requests and wake events.
   always_comb begin
      mode_nxt = mode_r;
      unique case (mode_r)
         tgd_pkg::single_osc_fast_run: begin
            if (stop_req) begin
               mode_nxt = tgd_pkg::stop_halted;
            end else if (ctl_r[tgd_pkg::CTL_LOW_EN]) begin
               mode_nxt = tgd_pkg::dual_osc_fast_run;
            end
         end
         tgd_pkg::dual_osc_fast_run: begin
            if (stop_req) begin
               mode_nxt = tgd_pkg::stop_halted;
            end else if (!ctl_r[tgd_pkg::CTL_LOW_EN]) begin
               mode_nxt = tgd_pkg::single_osc_fast_run;
            end else if (ctl_r[tgd_pkg::CTL_MAIN_SRC]) begin
               mode_nxt = tgd_pkg::dual_osc_slow_run;
            end
         end
         tgd_pkg::dual_osc_slow_run: begin
            if (!ctl_r[tgd_pkg::CTL_MAIN_SRC]) begin
               mode_nxt = tgd_pkg::dual_osc_fast_run;
            end else if (!ctl_r[tgd_pkg::CTL_HIGH_EN]) begin
               mode_nxt = tgd_pkg::low_osc_only_run;
            end
         end
         tgd_pkg::low_osc_only_run: begin
            if (stop_req) begin
               mode_nxt = tgd_pkg::stop_halted;
            end else if (sleep_req) begin
               mode_nxt = tgd_pkg::low_osc_halted_cpu;
            end else if (ctl_r[tgd_pkg::CTL_HIGH_EN]) begin
               mode_nxt = tgd_pkg::dual_osc_slow_run;
            end
         end
         tgd_pkg::low_osc_halted_cpu: begin
            if (wake_event) begin
               mode_nxt = tgd_pkg::low_osc_only_run;
            end
         end
         tgd_pkg::stop_halted: begin
            if (stop_release) begin
               mode_nxt = tgd_pkg::stop_warm_up;
            end
         end
         tgd_pkg::stop_warm_up: begin
            if (warm_done) begin
               mode_nxt = resume_r;
            end
         end
         default: mode_nxt = tgd_pkg::single_osc_fast_run;
      endcase
   end

   // Mode register; reset lands in single-clock fast run.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= tgd_pkg::single_osc_fast_run;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // Remember where stop was entered from, to resume and to pick the warm-up feed.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resume_r    <= tgd_pkg::single_osc_fast_run;
         from_fast_r <= 1'b1;
      end else if (mode_r != tgd_pkg::stop_halted && mode_nxt == tgd_pkg::stop_halted) begin
         resume_r    <= mode_r;
         from_fast_r <= (mode_r == tgd_pkg::single_osc_fast_run) ||
                        (mode_r == tgd_pkg::dual_osc_fast_run);
      end
   end

   // Warm-up after a slow-mode stop runs on the low clock, so that oscillator is kept.
   assign high_on   = osc_high(mode_r) && !(mode_r == tgd_pkg::stop_warm_up && !from_fast_r);
   assign low_on    = osc_low(mode_r) || (mode_r == tgd_pkg::stop_warm_up && !from_fast_r);
   assign hf_tick   = high_freq_clock && high_on;
   assign lf_tick   = low_freq_clock && low_on;
   assign fast_mode = (mode_r == tgd_pkg::single_osc_fast_run) ||
                      (mode_r == tgd_pkg::dual_osc_fast_run);
   assign slow_mode = (mode_r == tgd_pkg::dual_osc_slow_run) ||
                      (mode_r == tgd_pkg::low_osc_only_run);

   // ---------------------------------------------------------------
   // Prescaler and divider chain
   // ---------------------------------------------------------------
   // Chain clears on the edge that enters or leaves stop.
   assign clear_chain = (mode_r != tgd_pkg::stop_halted && mode_nxt == tgd_pkg::stop_halted) ||
                        (mode_r == tgd_pkg::stop_halted && mode_nxt != tgd_pkg::stop_halted);

   // Stage one is fed only while the high clock runs and the core is not asleep.
   assign stage1_in   = hf_tick && (pre_r == 2'h3) &&
                        (mode_r != tgd_pkg::low_osc_only_run) &&
                        (mode_r != tgd_pkg::low_osc_halted_cpu);
   assign stage6_fall = stage1_in && (low_div_r == 6'h3f);

   // Stage-seven feed: low clock in slow, sleep or slow warm-up, stage six during fast warm-up,
   // the select bit in fast run, none in stop; the bit is trusted not to pick a dead low clock.
   always_comb begin
      stage7_in = 1'b0;
      if (slow_mode || mode_r == tgd_pkg::low_osc_halted_cpu) begin
         stage7_in = lf_tick;
      end else if (mode_r == tgd_pkg::stop_warm_up) begin
         stage7_in = from_fast_r ? stage6_fall : lf_tick;
      end else if (fast_mode) begin
         stage7_in = ctl_r[tgd_pkg::CTL_STAGE7] ? lf_tick : stage6_fall;
      end
   end

   // Prescaler: two stages on the high clock.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_r <= 2'h0;
      end else if (clear_chain) begin
         pre_r <= 2'h0;
      end else if (hf_tick) begin
         pre_r <= pre_r + 2'h1;
      end
   end

   // Stages one to six.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_div_r <= 6'h00;
      end else if (clear_chain) begin
         low_div_r <= 6'h00;
      end else if (stage1_in) begin
         low_div_r <= low_div_r + 6'h01;
      end
   end

   // Stages seven to twenty-one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         high_div_r <= 15'h0000;
      end else if (clear_chain) begin
         high_div_r <= 15'h0000;
      end else if (stage7_in) begin
         high_div_r <= high_div_r + 15'h0001;
      end
   end

   // ---------------------------------------------------------------
   // Clock outputs
   // ---------------------------------------------------------------
   // Main clock: high clock in fast modes, low clock in slow modes, none when halted.
   assign main_tick_nxt = (fast_mode && hf_tick) || (slow_mode && lf_tick);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_clock_tick      <= 1'b0;
         divided_pulse_output <= 1'b0;
         source_clocks        <= 21'h000000;
         warm_up_tick         <= 1'b0;
         high_osc_run         <= 1'b1;
         low_osc_run          <= 1'b0;
         low_osc_pins_as_port <= 1'b1;
         cpu_run              <= 1'b1;
      end else begin
         main_clock_tick      <= main_tick_nxt;
         divided_pulse_output <= chain_w[tgd_pkg::PULSE_STAGE + 1];
         source_clocks        <= chain_w[22:2];
         warm_up_tick         <= (mode_r == tgd_pkg::stop_warm_up) && stage7_in;
         high_osc_run         <= high_on;
         low_osc_run          <= low_on;
         low_osc_pins_as_port <= !low_on;
         cpu_run              <= fast_mode || slow_mode;
      end
   end

   // ---------------------------------------------------------------
   // Machine cycle counting
   // ---------------------------------------------------------------
   tgd_cycle_counter u_cycles (
      .pclk         (pclk),
      .presetn      (presetn),
      .main_tick    (main_clock_tick),
      .cpu_run      (cpu_run),
      .instr_len    (instr_len_r),
      .state_r      (state_w),
      .cycle_r      (cycle_w),
      .instr_done_r (done_w)
   );

   assign machine_state = state_w;
   assign instr_done    = done_w;

endmodule

// ===== tb/tgd_monitor.sv
// Purpose: Concurrent checks on the ports of the timing generator.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes:   Bound from the testbench top file.
`timescale 1ns/10ps
module tgd_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic        pslverr,
   input wire logic        high_freq_clock,
   input wire logic        main_clock_tick,
   input wire logic        divided_pulse_output,
   input wire logic [20:0] source_clocks,
   input wire logic        high_osc_run,
   input wire logic        low_osc_run,
   input wire logic        low_osc_pins_as_port,
   input wire logic        cpu_run,
   input wire logic [1:0]  machine_state,
   input wire logic        instr_done
);
   // ------
   // Checks
   // ------
   // All checks share one clock, so defaults keep each property short.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_bad_addr_err: assert property (psel && penable |->
      pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c})) else $error("slave error wrong");
   a_port_pins:
      assert property (low_osc_pins_as_port == !low_osc_run) else $error("pin use wrong");
   a_state_step:
      assert property (machine_state != $past(machine_state) |->
         machine_state == $past(machine_state) + 2'd1) else $error("state skipped");
   a_instr_spacing:
      assert property (instr_done |=> !instr_done [*3]) else $error("instruction too short");
   a_dvo_stage:
      assert property (divided_pulse_output == source_clocks[12]) else $error("pulse output wrong");
   a_stop_clear:
      assert property (!high_osc_run && !low_osc_run [*2] |-> source_clocks == 21'h0)
         else $error("chain not clear in stop");
   // Checked only after a full cycle in low-only run, so the entry edge is left out.
   a_low_freeze:
      assert property (!high_osc_run && low_osc_run && cpu_run
         && $past(!high_osc_run && low_osc_run && cpu_run) |-> $stable(source_clocks[5:0]))
         else $error("low stages moved");
   a_fast_tick:
      assert property (cpu_run && high_osc_run && !low_osc_run && $past(cpu_run)
         |-> main_clock_tick == $past(high_freq_clock)) else $error("main tick not from high clock");
endmodule

// ===== tb/tgd_timing_gen_test.sv
// Purpose: Self-checking bench of the timing generator.
// Assumes: The high clock ticks every cycle when enabled, the low clock every eight cycles.
// Notes:   Each scenario is one task; stop release from fast run is long.
`timescale 1ns/10ps
module tgd_timing_gen_test;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic        pready, pslverr, rerr, hf_on = 1'b0;
   logic        high_freq_clock = 1'b0, low_freq_clock = 1'b0;
   logic        stop_release = 1'b0, wake_event = 1'b0;
   logic        main_clock_tick, divided_pulse_output, warm_up_tick, high_osc_run;
   logic        low_osc_run, low_osc_pins_as_port, cpu_run, instr_done;
   logic [1:0]  machine_state;
   logic [20:0] source_clocks;
   logic [22:0] watch;
   logic [5:0]  low6;
   logic [2:0]  lf_cnt = 3'h0;
   int          errors = 0, samples_checked = 0;

   tgd_timing_gen dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .high_freq_clock(high_freq_clock), .low_freq_clock(low_freq_clock),
      .stop_release(stop_release), .wake_event(wake_event), .main_clock_tick(main_clock_tick),
      .divided_pulse_output(divided_pulse_output), .source_clocks(source_clocks),
      .warm_up_tick(warm_up_tick), .high_osc_run(high_osc_run), .low_osc_run(low_osc_run),
      .low_osc_pins_as_port(low_osc_pins_as_port), .cpu_run(cpu_run),
      .machine_state(machine_state), .instr_done(instr_done));

   assign watch = {warm_up_tick, instr_done, source_clocks};

   // -------------
   // Clock, ticks
   // -------------
   // A fast low clock keeps the slow-mode checks short; only ratios matter here.
   always #2 pclk = ~pclk;
   always @(posedge pclk) begin
      lf_cnt <= lf_cnt + 3'h1;
      low_freq_clock <= (lf_cnt == 3'h7);
      high_freq_clock <= hf_on;
   end

   // -------------
   // Shared tasks
   // -------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; read data and error are taken at the completing edge.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_mode(input logic [2:0] m, input int lim);
      for (int i = 0; i < lim; i++) begin
         bus(1'b0, tgd_pkg::OFS_STATUS, 32'h0);
         if (rdat[2:0] === m) break;
      end
      chk({29'h0, rdat[2:0]}, {29'h0, m});
   endtask

   // Measures the period of one watched bit, rising edge to rising edge.
   task automatic per(input int b, input int e);
      int n;
      n = 0;
      do @(negedge pclk); while (watch[b] !== 1'b0);
      do @(negedge pclk); while (watch[b] !== 1'b1);
      do begin @(negedge pclk); n++; end while (watch[b] !== 1'b0);
      do begin @(negedge pclk); n++; end while (watch[b] !== 1'b1);
      chk(n, e);
   endtask

   task automatic pulse_release;
      stop_release <= 1'b1;
      @(posedge pclk);
      stop_release <= 1'b0;
   endtask

   // -------------
   // Scenarios
   // -------------
   task automatic t_reset;
      bus(1'b0, tgd_pkg::OFS_CONTROL, 32'h0);
      chk(rdat, 32'h8);
      bus(1'b0, tgd_pkg::OFS_STATUS, 32'h0);
      chk(rdat & 32'h3c7, 32'h340);
      bus(1'b0, tgd_pkg::OFS_DIVIDER, 32'h0);
      chk(rdat, 32'h0);
      bus(1'b0, 8'h10, 32'h0);
      chk({rdat[30:0], rerr}, 32'h1);
      hf_on <= 1'b1;
   endtask

   task automatic t_chain;
      for (int b = 0; b < 7; b++) per(b, 8 << b);
   endtask

   // Lengths outside one to ten are clamped to the nearest limit.
   task automatic t_instr;
      bus(1'b1, tgd_pkg::OFS_INSTR, 32'h0);
      bus(1'b0, tgd_pkg::OFS_INSTR, 32'h0);
      chk(rdat[3:0], tgd_pkg::INSTR_MIN);
      bus(1'b1, tgd_pkg::OFS_INSTR, 32'hb);
      bus(1'b0, tgd_pkg::OFS_INSTR, 32'h0);
      chk(rdat[3:0], tgd_pkg::INSTR_MAX);
      per(21, 40);
      bus(1'b1, tgd_pkg::OFS_INSTR, 32'h2);
      per(21, 8);
   endtask

   task automatic t_slow;
      bus(1'b1, tgd_pkg::OFS_CONTROL, 32'hc);
      wait_mode(3'h1, 1);
      bus(1'b1, tgd_pkg::OFS_CONTROL, 32'hd);
      wait_mode(3'h2, 1);
      per(6, 16);
      bus(1'b1, tgd_pkg::OFS_CONTROL, 32'h5);
      wait_mode(3'h3, 1);
      low6 = source_clocks[5:0];
      repeat (40) @(posedge pclk);
      chk(source_clocks[5:0], low6);
      bus(1'b1, tgd_pkg::OFS_CONTROL, 32'h25);
      wait_mode(3'h4, 1);
      chk(cpu_run, 1'b0);
      wake_event <= 1'b1;
      @(posedge pclk);
      wake_event <= 1'b0;
      wait_mode(3'h3, 2);
      bus(1'b1, tgd_pkg::OFS_CONTROL, 32'h15);
      wait_mode(3'h5, 1);
      bus(1'b0, tgd_pkg::OFS_DIVIDER, 32'h0);
      chk(rdat, 32'h0);
      pulse_release();
      wait_mode(3'h6, 1);
      per(22, 8);
      wait_mode(3'h3, 600);
   endtask

   task automatic t_fast_stop;
      bus(1'b1, tgd_pkg::OFS_CONTROL, 32'hd);
      bus(1'b1, tgd_pkg::OFS_CONTROL, 32'he);
      wait_mode(3'h1, 1);
      per(6, 16);
      bus(1'b1, tgd_pkg::OFS_CONTROL, 32'h1e);
      wait_mode(3'h5, 1);
      chk(source_clocks, 32'h0);
      pulse_release();
      wait_mode(3'h6, 1);
      per(6, 512);
      per(22, 256);
      wait_mode(3'h1, 12000);
      per(6, 16);
      bus(1'b1, tgd_pkg::OFS_CONTROL, 32'h8);
      wait_mode(3'h0, 1);
   endtask

   // -------------
   // Run control
   // -------------
   task automatic report_and_stop;
      if (errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_chain();
      t_instr();
      t_slow();
      t_fast_stop();
      report_and_stop();
   end

   // The long warm-up from fast run dominates; this leaves more than double margin.
   initial begin
      repeat (90000) @(posedge pclk);
      errors++;
      report_and_stop();
   end
endmodule

bind tgd_timing_gen tgd_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .paddr(paddr), .pslverr(pslverr), .high_freq_clock(high_freq_clock),
   .main_clock_tick(main_clock_tick), .divided_pulse_output(divided_pulse_output),
   .source_clocks(source_clocks), .high_osc_run(high_osc_run), .low_osc_run(low_osc_run),
   .low_osc_pins_as_port(low_osc_pins_as_port), .cpu_run(cpu_run),
   .machine_state(machine_state), .instr_done(instr_done));
